// [tb/clock_source_model.sv]
// Behavioural clock sources outside the codec clock controller
`timescale 1ns/1ps
`default_nettype none
module clock_source_model (
  // Loop controls
  input  wire logic i_loop_enable,
  input  wire logic i_loop_osc_enable,
  // Sources
  output logic      o_master_clock,
  output logic      o_loop_clock,
  output logic      o_crystal
);
  // Master clock pin and reference run free, far below the sampling rate
  initial
  begin
    o_master_clock = 1'b0;
    forever #32 o_master_clock = ~o_master_clock;
  end
  initial
  begin
    o_crystal = 1'b0;
    forever #100 o_crystal = ~o_crystal;
  end
  // Loop runs only with both enables; dropping one gives the switch a fall
  initial
  begin
    o_loop_clock = 1'b0;
    forever #24 o_loop_clock = i_loop_enable & i_loop_osc_enable & ~o_loop_clock;
  end
endmodule
`default_nettype wire

// [tb/codec_clock_control_bench.sv]
// Self-checking bench for the codec clock controller
`timescale 1ns/1ps
`default_nettype none
`include "codec_clock_cfg.svh"
module codec_clock_control_bench;
  logic        i_clock, i_rst_n, i_reg_write, i_reg_read, i_low_power_state, i_gpio_ref_in;
  logic [7:0]  i_reg_addr;
  logic [15:0] i_reg_wdata, o_reg_rdata, rd, v, w;
  logic        o_reg_rvalid, i_master_clock_pin, i_loop_clock, i_crystal_in_pin, o_ref_clock;
  logic        o_ref_osc_enable, o_loop_enable, o_loop_osc_enable, o_codec_core_clock;
  logic        o_rec_core_clock, o_play_core_clock, o_timeout_clock, o_rate_mode_usb;
  logic        o_bit_clock, o_bit_clock_oe, o_rec_frame_clock, o_rec_frame_clock_oe;
  logic        o_play_frame_clock, o_play_frame_clock_oe, o_alt_rec_frame_clock;
  logic        o_alt_rec_frame_inv, o_alt_rec_bit_clock, o_alt_oe;
  logic [3:0]  o_gpio_out, o_gpio_oe;
  int          fails, comparisons, seed, i, nr, nc, nt, ng, nb;
  // Design and far-side clock sources
  codec_clock_control #(.TIMEOUT_BASE_EDGES(24'h000004)) u_codec_clock_control (.*);
  clock_source_model u_clock_source_model (
    .i_loop_enable     (o_loop_enable),
    .i_loop_osc_enable (o_loop_osc_enable),
    .o_master_clock    (i_master_clock_pin),
    .o_loop_clock      (i_loop_clock),
    .o_crystal         (i_crystal_in_pin)
  );
  // 125 MHz clock
  initial
  begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  // Comparison, verdict and register cycles
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic give_up;
    fails++;
    final_report();
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_write <= 1'b1;
    @(posedge i_clock);
    i_reg_write <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_clock);
    i_reg_read <= 1'b0;
    @(negedge i_clock);
    if (o_reg_rvalid !== 1'b1)
      give_up();
    rd = o_reg_rdata;
  endtask
  // Rising edges of reference, core, timeout, GPIO 5 and bit clocks over 480 cycles
  task automatic count_rises;
    logic [4:0] p;
    logic [4:0] s;
    repeat (16) @(negedge i_clock);
    nr = 0;
    nc = 0;
    nt = 0;
    ng = 0;
    nb = 0;
    p = {o_ref_clock, o_codec_core_clock, o_timeout_clock, o_gpio_out[2], o_bit_clock};
    repeat (480)
    begin
      @(negedge i_clock);
      s = {o_ref_clock, o_codec_core_clock, o_timeout_clock, o_gpio_out[2], o_bit_clock};
      nr += int'(s[4] & ~p[4]);
      nc += int'(s[3] & ~p[3]);
      nt += int'(s[2] & ~p[2]);
      ng += int'(s[1] & ~p[1]);
      nb += int'(s[0] & ~p[0]);
      p = s;
    end
  endtask
  // Expected rise count for a source period, with sampling slack
  function automatic logic [15:0] near(input int got, input int period_ns);
    int e;
    e = 3840 / period_ns;
    return 16'(got >= e - 2 && got <= e + 2);
  endfunction
  // Converter clock rises within one whole frame, skipping the first
  task automatic frame_len;
    int k, seen;
    logic pf, pc;
    nc = 0;
    seen = 0;
    pf = 1'b1;
    pc = 1'b1;
    for (k = 0; k < 40000 && seen < 3; k++)
    begin
      @(negedge i_clock);
      nc += int'(seen == 2 && o_play_core_clock && !pc);
      seen += int'(o_play_frame_clock && !pf);
      pf = o_play_frame_clock;
      pc = o_play_core_clock;
    end
    if (seen < 3)
      give_up();
  endtask
  // Main sequence
  initial
  begin
    seed = 45541;
    fails = 0;
    comparisons = 0;
    i_rst_n = 1'b0;
    i_reg_write = 1'b0;
    i_reg_read = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 16'h0000;
    i_low_power_state = 1'b0;
    i_gpio_ref_in = 1'b0;
    repeat (4) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rdr(`ADDR_POWER_MGMT5);
    check("osc reset", 16'h0400, rd & 16'h0400);
    rdr(`ADDR_CLOCK_CTRL1);
    check("ctrl reset", 16'h0000, rd & 16'h0900);
    rdr(`ADDR_PLAY_CTRL);
    check("mode reset", 16'h0000, rd & 16'h1000);
    wr(`ADDR_POWER_MGMT5, 16'h0000);
    rdr(`ADDR_TICK_ALIAS);
    check("locked", 16'h1000, rd & 16'h1000);
    wr(`ADDR_SECURITY, 16'h0013);
    @(posedge i_clock);
    i_low_power_state <= 1'b1;
    wr(`ADDR_TICK_ALIAS, 16'h0000);
    @(negedge i_clock);
    check("low power", 16'h0001, {15'h0, o_ref_osc_enable});
    @(posedge i_clock);
    i_low_power_state <= 1'b0;
    wr(`ADDR_POWER_MGMT5, 16'h0000);
    rdr(`ADDR_TICK_ALIAS);
    check("alias clear", 16'h0000, rd & 16'h1000);
    count_rises();
    check("ref stopped", 16'h0000, 16'(nr));
    wr(`ADDR_TICK_ALIAS, 16'h1000);
    rdr(`ADDR_POWER_MGMT5);
    check("alias set", 16'h0400, rd & 16'h0400);
    count_rises();
    check("ref runs", 16'h0001, near(nr, 200));
    check("core pin", 16'h0001, near(nc, 64));
    wr(`ADDR_CLOCK_CTRL1, 16'h0100);
    count_rises();
    check("core half", 16'h0001, near(nc, 128));
    wr(`ADDR_CLOCK_CTRL2, 16'h0200);
    wr(`ADDR_CLOCK_CTRL2, 16'h0700);
    wr(`ADDR_CLOCK_CTRL1, 16'h0800);
    count_rises();
    check("core loop", 16'h0001, near(nc, 48));
    wr(`ADDR_CLOCK_CTRL1, 16'h0000);
    wr(`ADDR_CLOCK_CTRL2, 16'h0600);
    wr(`ADDR_CLOCK_CTRL2, 16'h0400);
    count_rises();
    check("core back", 16'h0001, near(nc, 64));
    // Timeout at four core edges, output divider at four edges onto GPIO 5
    wr(`ADDR_CLOCK_CTRL2, 16'h0411);
    wr(`ADDR_GPIO_CLOCK, 16'h0010);
    count_rises();
    check("timeout clock", 16'h0001, near(nt, 128));
    check("gpio 5 clock", 16'h0001, near(ng, 128));
    check("bit clock", 16'h0001, near(nb, 64));
    $display("test clock sources done");
    for (i = 0; i < 4; i++)
    begin
      v = 16'($random(seed));
      w = 16'($random(seed));
      wr(`ADDR_REC_RATE, v);
      wr(`ADDR_PLAY_RATE, w);
      rdr(`ADDR_REC_RATE);
      check("rec rate", v & 16'h0007, rd & 16'h0007);
      rdr(`ADDR_PLAY_RATE);
      check("play rate", w & 16'h0007, rd & 16'h0007);
    end
    for (i = 0; i < 2; i++)
    begin
      wr(`ADDR_PLAY_RATE, 16'($unsigned($random(seed)) % 3));
      wr(`ADDR_PLAY_CTRL, 16'(i) << 12);
      frame_len();
      check("frame", 16'(256 + 16 * i), 16'(nc));
      check("usb bit", 16'(i), {15'h0, o_rate_mode_usb});
    end
    wr(`ADDR_GPIO_CLOCK, 16'h000f);
    @(negedge i_clock);
    check("ref out oe", 16'h000f, {12'h0, o_gpio_oe});
    wr(`ADDR_CLOCK_CTRL1, 16'h0900);
    wr(`ADDR_SW_RESET, 16'h0000);
    rdr(`ADDR_CLOCK_CTRL1);
    check("sw reset", 16'h0000, rd & 16'h0900);
    check("oe cleared", 16'h0000, {12'h0, o_gpio_oe});
    $display("test rates and reset done");
    final_report();
  end
endmodule
`default_nettype wire

// [verilog/codec_clock_cfg.svh]
// Register map, field positions and reset values of the codec clock controller
`ifndef CODEC_CLOCK_CFG_SVH
`define CODEC_CLOCK_CFG_SVH

// ********************************
// Register offsets
// ********************************
`define ADDR_SW_RESET      8'h00
`define ADDR_POWER_MGMT5   8'h0c
`define ADDR_CLOCK_CTRL1   8'h28
`define ADDR_CLOCK_CTRL2   8'h29
`define ADDR_BIT_CLOCK     8'h2a
`define ADDR_GPIO_CLOCK    8'h2b
`define ADDR_PLAY_CTRL     8'h30
`define ADDR_PLAY_RATE     8'h36
`define ADDR_REC_RATE      8'h44
`define ADDR_TICK_ALIAS    8'hda
`define ADDR_SECURITY      8'hdb

// ********************************
// Field positions
// ********************************
`define BIT_OSC_PM5        10
`define BIT_OSC_TICK       12
`define BIT_SRC_SELECT     11
`define BIT_SRC_DIVIDE     8
`define BIT_RATE_MODE      12
`define FLD_RATE_CODE      2:0
`define FLD_OUT_DIV        3:0
`define BIT_TIMEOUT_EN     4
`define FLD_TIMEOUT_RATE   7:5
`define BIT_LOOP_EN        8
`define BIT_LOOP_OSC_EN    9
`define BIT_MASTER_MODE    10
`define BIT_ALT_REC_PINS   11
`define BIT_REC_INV_EN     12
`define FLD_CLK2           12:0
`define FLD_BIT_DIV        5:0
`define FLD_REF_OUT_EN     3:0
`define BIT_GPIO5_OUTCLK   4
`define BIT_EXT_REF_GPIO   5
`define FLD_GPIO_CFG       5:0

// ********************************
// Reset values and constants
// ********************************
`define OSC_RESET          1'b1
`define SEL_RESET          1'b0
`define UNLOCK_KEY         16'h0013
`define FRAME_NORMAL       9'h100
`define FRAME_USB          9'h110
`define RATE_LEN_1_0       5'h02
`define RATE_LEN_1_5       5'h03
`define RATE_LEN_2_0       5'h04
`define RATE_LEN_3_0       5'h06
`define RATE_LEN_4_0       5'h08
`define RATE_LEN_5_5       5'h0b
`define RATE_LEN_6_0       5'h0c
`define GPIO5_INDEX        2

`endif

// [verilog/codec_clock_control.sv]
// Codec clock controller: reference gate, core clock switch, rate and pin dividers
`timescale 1ns/1ps
`default_nettype none
`include "codec_clock_cfg.svh"

module codec_clock_control
  import codec_clock_pkg::*;
#(
  parameter logic [15:0] CHIP_ID            = 16'h5a5a, // Arbitrary identification value
  parameter logic [23:0] TIMEOUT_BASE_EDGES = 24'h000100
) (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // Register port
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic       i_reg_write,
  input  wire logic       i_reg_read,
  output logic [15:0]     o_reg_rdata,
  output logic            o_reg_rvalid,
  // Clock sources and power state
  input  wire logic       i_master_clock_pin,
  input  wire logic       i_loop_clock,
  input  wire logic       i_crystal_in_pin,
  input  wire logic       i_gpio_ref_in,
  input  wire logic       i_low_power_state,
  // Oscillator and loop controls
  output logic            o_ref_osc_enable,
  output logic            o_loop_enable,
  output logic            o_loop_osc_enable,
  output logic            o_ref_clock,
  // Internal clocks
  output logic            o_codec_core_clock,
  output logic            o_rec_core_clock,
  output logic            o_play_core_clock,
  output logic            o_timeout_clock,
  output logic            o_rate_mode_usb,
  // Audio interface pins
  output logic            o_bit_clock,
  output logic            o_bit_clock_oe,
  output logic            o_rec_frame_clock,
  output logic            o_rec_frame_clock_oe,
  output logic            o_play_frame_clock,
  output logic            o_play_frame_clock_oe,
  // Alternate recording pins
  output logic            o_alt_rec_frame_clock,
  output logic            o_alt_rec_frame_inv,
  output logic            o_alt_rec_bit_clock,
  output logic            o_alt_oe,
  // GPIO reference outputs (GPIO 2, 3, 5, 12)
  output logic [3:0]      o_gpio_out,
  output logic [3:0]      o_gpio_oe
);

  // ********************************
  // Register storage
  // ********************************
  logic          ref_osc_enable_q;
  logic          src_select_q;
  logic          src_divide_q;
  logic          rate_mode_q;
  rate_code_t    rec_code_q;
  rate_code_t    play_code_q;
  logic [12:0]   clk2_q;
  logic [5:0]    bit_div_q;
  logic [5:0]    gpio_cfg_q;
  reg_word_t     security_q;

  // Write decode
  logic wr_soft_reset, wr_pm5, wr_tick, unlocked;
  assign unlocked      = (security_q == `UNLOCK_KEY);
  assign wr_soft_reset = i_reg_write & (i_reg_addr == `ADDR_SW_RESET);
  assign wr_pm5        = i_reg_write & (i_reg_addr == `ADDR_POWER_MGMT5) & unlocked;
  assign wr_tick       = i_reg_write & (i_reg_addr == `ADDR_TICK_ALIAS);

  // Shared oscillator enable, held on in low power states
  logic osc_d;
  assign osc_d = i_low_power_state ? `OSC_RESET :
                 wr_pm5  ? i_reg_wdata[`BIT_OSC_PM5] :
                 wr_tick ? i_reg_wdata[`BIT_OSC_TICK] : ref_osc_enable_q;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      ref_osc_enable_q <= `OSC_RESET;
    else
      ref_osc_enable_q <= osc_d;
  end

  // Clock control fields; software reset restores defaults
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n || wr_soft_reset)
    begin
      src_select_q <= `SEL_RESET;
      src_divide_q <= 1'b0;
      rate_mode_q  <= 1'b0;
      rec_code_q   <= '0;
      play_code_q  <= '0;
      clk2_q       <= '0;
      bit_div_q    <= '0;
      gpio_cfg_q   <= '0;
      security_q   <= '0;
    end
    else if (i_reg_write)
    begin
      case (i_reg_addr)
        `ADDR_CLOCK_CTRL1:
        begin
          src_select_q <= i_reg_wdata[`BIT_SRC_SELECT];
          src_divide_q <= i_reg_wdata[`BIT_SRC_DIVIDE];
        end
        `ADDR_CLOCK_CTRL2: clk2_q      <= i_reg_wdata[`FLD_CLK2];
        `ADDR_BIT_CLOCK:   bit_div_q   <= i_reg_wdata[`FLD_BIT_DIV];
        `ADDR_GPIO_CLOCK:  gpio_cfg_q  <= i_reg_wdata[`FLD_GPIO_CFG];
        `ADDR_PLAY_CTRL:   rate_mode_q <= i_reg_wdata[`BIT_RATE_MODE];
        `ADDR_PLAY_RATE:   play_code_q <= i_reg_wdata[`FLD_RATE_CODE];
        `ADDR_REC_RATE:    rec_code_q  <= i_reg_wdata[`FLD_RATE_CODE];
        `ADDR_SECURITY:    security_q  <= i_reg_wdata;
        default:           security_q  <= security_q;
      endcase
    end
  end

  // Read decode
  reg_word_t rd_word;
  assign rd_word =
    (i_reg_addr == `ADDR_SW_RESET)    ? CHIP_ID :
    (i_reg_addr == `ADDR_POWER_MGMT5) ? reg_word_t'(ref_osc_enable_q) << `BIT_OSC_PM5 :
    (i_reg_addr == `ADDR_TICK_ALIAS)  ? reg_word_t'(ref_osc_enable_q) << `BIT_OSC_TICK :
    (i_reg_addr == `ADDR_CLOCK_CTRL1) ? (reg_word_t'(src_select_q) << `BIT_SRC_SELECT) |
                                        (reg_word_t'(src_divide_q) << `BIT_SRC_DIVIDE) :
    (i_reg_addr == `ADDR_CLOCK_CTRL2) ? reg_word_t'(clk2_q) :
    (i_reg_addr == `ADDR_BIT_CLOCK)   ? reg_word_t'(bit_div_q) :
    (i_reg_addr == `ADDR_GPIO_CLOCK)  ? reg_word_t'(gpio_cfg_q) :
    (i_reg_addr == `ADDR_PLAY_CTRL)   ? reg_word_t'(rate_mode_q) << `BIT_RATE_MODE :
    (i_reg_addr == `ADDR_PLAY_RATE)   ? reg_word_t'(play_code_q) :
    (i_reg_addr == `ADDR_REC_RATE)    ? reg_word_t'(rec_code_q) :
    (i_reg_addr == `ADDR_SECURITY)    ? security_q : '0;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_reg_rdata  <= '0;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rdata  <= i_reg_read ? rd_word : o_reg_rdata;
      o_reg_rvalid <= i_reg_read;
    end
  end

  // ********************************
  // Source synchronisers and reference
  // ********************************
  logic mclk_s, loop_s, xtal_s, gref_s;
  level_sync #(.W(4)) u_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async ({i_master_clock_pin, i_loop_clock, i_crystal_in_pin, i_gpio_ref_in}),
    .o_sync  ({mclk_s, loop_s, xtal_s, gref_s})
  );

  // Reference gated by the oscillator enable, from crystal pin or GPIO
  logic ref_q;
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      ref_q <= 1'b0;
    else
      ref_q <= ref_osc_enable_q & (gpio_cfg_q[`BIT_EXT_REF_GPIO] ? gref_s : xtal_s);
  end

  // ********************************
  // Core clock source switch
  // ********************************
  switch_state_t state_q, state_d;
  logic cur_sel_q, cur_sel_d, core_q, core_d;
  logic mclk_prev_q, loop_prev_q;
  logic src_now, src_prev, src_rise, src_fall, switch_now, core_edge;

  assign src_now   = cur_sel_q ? loop_s : mclk_s;
  assign src_prev  = cur_sel_q ? loop_prev_q : mclk_prev_q;
  assign src_rise  = src_now & ~src_prev;
  assign src_fall  = ~src_now & src_prev;
  assign core_edge = core_d ^ core_q;

  // Wait for a falling edge of the old source before moving over
  always_comb
  begin
    state_d    = state_q;
    cur_sel_d  = cur_sel_q;
    switch_now = 1'b0;
    case (state_q)
      SW_RUN:
        if (src_select_q != cur_sel_q)
          state_d = SW_WAIT_FALL;
      SW_WAIT_FALL:
        if (src_select_q == cur_sel_q)
          state_d = SW_RUN;
        else if (src_fall)
        begin
          cur_sel_d  = src_select_q;
          switch_now = 1'b1;
          state_d    = SW_RUN;
        end
      default:
        state_d = SW_RUN;
    endcase
  end

  // Divide by one follows the source, divide by two toggles on rises
  assign core_d = switch_now ? 1'b0 :
                  src_divide_q ? (src_rise ? ~core_q : core_q) : src_now;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      state_q     <= SW_RUN;
      cur_sel_q   <= `SEL_RESET;
      core_q      <= 1'b0;
      mclk_prev_q <= 1'b0;
      loop_prev_q <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      cur_sel_q   <= cur_sel_d;
      core_q      <= core_d;
      mclk_prev_q <= mclk_s;
      loop_prev_q <= loop_s;
    end
  end

  // ********************************
  // Converter, frame and pin dividers
  // ********************************
  function automatic logic [4:0] rate_len(input rate_code_t code);
    case (code)
      3'h0:    rate_len = `RATE_LEN_1_0;
      3'h1:    rate_len = `RATE_LEN_1_5;
      3'h2:    rate_len = `RATE_LEN_2_0;
      3'h3:    rate_len = `RATE_LEN_3_0;
      3'h4:    rate_len = `RATE_LEN_4_0;
      3'h5:    rate_len = `RATE_LEN_5_5;
      3'h6:    rate_len = `RATE_LEN_6_0;
      default: rate_len = `RATE_LEN_1_0; // Reserved code runs undivided
    endcase
  endfunction

  logic       master, alt_pins, frame_restart;
  logic [4:0] conv_len  [2];
  logic [8:0] frame_len;
  logic [1:0] conv_clk, conv_wrap, frame_clk, frame_wrap;
  assign master        = clk2_q[`BIT_MASTER_MODE];
  assign alt_pins      = clk2_q[`BIT_ALT_REC_PINS];
  assign frame_restart = ~master;
  assign conv_len[0]   = rate_len(rec_code_q);
  assign conv_len[1]   = rate_len(play_code_q);
  assign frame_len     = rate_mode_q ? `FRAME_USB : `FRAME_NORMAL;

  // Channel 0 records, channel 1 plays, each with its own divider
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    edge_divider #(.W(5)) u_conv (
      .i_clock (i_clock), .i_rst_n (i_rst_n), .i_restart (1'b0),
      .i_edge  (core_edge), .i_len (conv_len[ch]),
      .o_clk   (conv_clk[ch]), .o_wrap (conv_wrap[ch])
    );
    edge_divider #(.W(9)) u_frame (
      .i_clock (i_clock), .i_rst_n (i_rst_n), .i_restart (frame_restart),
      .i_edge  (conv_wrap[ch]), .i_len (frame_len),
      .o_clk   (frame_clk[ch]), .o_wrap (frame_wrap[ch])
    );
  end

  // Bit clock restarts on the faster frame so edges stay aligned
  logic       bit_clk, faster_wrap;
  logic [7:0] bit_len;
  assign faster_wrap = (conv_len[0] <= conv_len[1]) ? frame_wrap[0] : frame_wrap[1];
  assign bit_len     = {1'b0, ({1'b0, bit_div_q} + 7'h01)} << 1;
  edge_divider #(.W(8)) u_bit (
    .i_clock (i_clock), .i_rst_n (i_rst_n), .i_restart (frame_restart | faster_wrap),
    .i_edge  (core_edge), .i_len (bit_len), .o_clk (bit_clk), .o_wrap ()
  );

  // Output clock on GPIO 5
  logic       out_clk;
  logic [5:0] out_len;
  assign out_len = {({1'b0, clk2_q[`FLD_OUT_DIV]} + 5'h01), 1'b0};
  edge_divider #(.W(6)) u_out (
    .i_clock (i_clock), .i_rst_n (i_rst_n), .i_restart (1'b0),
    .i_edge  (core_edge), .i_len (out_len), .o_clk (out_clk), .o_wrap ()
  );

  // Slow timeout clock, held high with its counter at zero while disabled
  logic        to_en;
  logic [23:0] to_len;
  assign to_en  = clk2_q[`BIT_TIMEOUT_EN];
  assign to_len = TIMEOUT_BASE_EDGES << clk2_q[`FLD_TIMEOUT_RATE];
  edge_divider #(.W(24)) u_timeout (
    .i_clock (i_clock), .i_rst_n (i_rst_n), .i_restart (~to_en),
    .i_edge  (core_edge), .i_len (to_len), .o_clk (o_timeout_clock), .o_wrap ()
  );

  // ********************************
  // Pin outputs
  // ********************************
  logic [3:0] gpio_q;
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      gpio_q <= '0;
    else
    begin
      gpio_q <= {4{ref_q}};
      if (gpio_cfg_q[`BIT_GPIO5_OUTCLK])
        gpio_q[`GPIO5_INDEX] <= out_clk;
    end
  end

  assign o_gpio_out = gpio_q;
  assign o_gpio_oe  = gpio_cfg_q[`FLD_REF_OUT_EN] |
                      (4'h1 << `GPIO5_INDEX) & {4{gpio_cfg_q[`BIT_GPIO5_OUTCLK]}};
  assign o_ref_osc_enable      = ref_osc_enable_q;
  assign o_loop_enable         = clk2_q[`BIT_LOOP_EN];
  assign o_loop_osc_enable     = clk2_q[`BIT_LOOP_OSC_EN];
  assign o_ref_clock           = ref_q;
  assign o_codec_core_clock    = core_q;
  assign o_rec_core_clock      = conv_clk[0];
  assign o_play_core_clock     = conv_clk[1];
  assign o_rate_mode_usb       = rate_mode_q;
  assign o_bit_clock           = bit_clk;
  assign o_bit_clock_oe        = master;
  assign o_rec_frame_clock     = frame_clk[0];
  assign o_rec_frame_clock_oe  = master & ~alt_pins;
  assign o_play_frame_clock    = frame_clk[1];
  assign o_play_frame_clock_oe = master;
  assign o_alt_rec_frame_clock = frame_clk[0];
  assign o_alt_rec_frame_inv   = clk2_q[`BIT_REC_INV_EN] & ~frame_clk[0];
  assign o_alt_rec_bit_clock   = bit_clk;
  assign o_alt_oe              = master & alt_pins;

  // ********************************
  // Assertions
  // ********************************
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_osc_reset;
    $past(!i_rst_n) && !i_reg_write |-> ref_osc_enable_q;
  endproperty
  a_osc_reset: assert property (p_osc_reset) else $error("oscillator enable not set after reset");

  property p_low_power;
    i_low_power_state |=> ref_osc_enable_q ##1 o_ref_osc_enable;
  endproperty
  a_low_power: assert property (p_low_power) else $error("oscillator dropped in low power");

  property p_alias;
    wr_tick && !i_low_power_state |=> ref_osc_enable_q == $past(i_reg_wdata[`BIT_OSC_TICK]);
  endproperty
  a_alias: assert property (p_alias) else $error("alias write missed shared enable");

  property p_lock;
    i_reg_write && i_reg_addr == `ADDR_POWER_MGMT5 && security_q != `UNLOCK_KEY
      && !i_low_power_state |=> $stable(ref_osc_enable_q);
  endproperty
  a_lock: assert property (p_lock) else $error("locked register was written");

  property p_switch_on_fall;
    cur_sel_q != $past(cur_sel_q) |-> $past(src_fall) && !core_q;
  endproperty
  a_switch_on_fall: assert property (p_switch_on_fall) else $error("switch without old falling edge");

  property p_soft_reset;
    wr_soft_reset |=> !src_select_q ##1 !src_select_q || $past(i_reg_write);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("software reset kept loop source");

  property p_usb_frame;
    rate_mode_q |-> frame_len == `FRAME_USB;
  endproperty
  a_usb_frame: assert property (p_usb_frame) else $error("usb mode frame length wrong");

  property p_gpio5_clock;
    gpio_cfg_q[`BIT_GPIO5_OUTCLK] && $stable(gpio_cfg_q) |=> o_gpio_out[`GPIO5_INDEX] == $past(out_clk);
  endproperty
  a_gpio5_clock: assert property (p_gpio5_clock) else $error("gpio 5 not carrying output clock");

  property p_alt_pins;
    alt_pins |-> !o_rec_frame_clock_oe && (o_alt_oe == master);
  endproperty
  a_alt_pins: assert property (p_alt_pins) else $error("primary recording pin still driven");
endmodule
`default_nettype wire

// [verilog/codec_clock_pkg.sv]
// Types shared by the codec clock controller modules
`default_nettype none
package codec_clock_pkg;
  typedef enum logic {SW_RUN, SW_WAIT_FALL} switch_state_t;
  typedef logic [2:0]  rate_code_t;
  typedef logic [15:0] reg_word_t;
endpackage
`default_nettype wire

// [verilog/edge_divider.sv]
// Event counting divider producing a registered clock level
`timescale 1ns/1ps
`default_nettype none
module edge_divider #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst_n,
  // Control
  input  wire logic         i_restart,
  input  wire logic         i_edge,
  input  wire logic [W-1:0] i_len,
  // Result
  output logic              o_clk,
  output logic              o_wrap
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W-1:0] half;
  logic         last;

  // One period is i_len events, high for the first half
  assign half   = i_len >> 1;
  assign last   = (cnt_q >= (i_len - W'(1)));
  assign o_wrap = i_edge & last & ~i_restart;
  assign cnt_d  = i_restart ? '0 : (i_edge ? (last ? '0 : cnt_q + W'(1)) : cnt_q);

  // Counter and output level
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= '0;
      o_clk <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      o_clk <= (cnt_d < half);
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_wrap_high;
    o_wrap && (i_len > W'(1)) && !i_restart |=> o_clk;
  endproperty
  a_wrap_high: assert property (p_wrap_high) else $error("period does not restart high");
endmodule
`default_nettype wire

// [verilog/level_sync.sv]
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst_n,
  // Levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] stage1_q;

  // First stage feeds only the second
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      stage1_q <= '0;
      o_sync   <= '0;
    end
    else
    begin
      stage1_q <= i_async;
      o_sync   <= stage1_q;
    end
  end
endmodule
`default_nettype wire
